// ==== design/sbu_pkg.sv ====
// Package for the serial bus user port: widths, reset values and state codes.
package sbu_pkg;
	localparam int DATA_W = 8;
	localparam int ID_W = 4;
	localparam int NUM_REGS = 16;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] CARRIER_ID_ADDR = 8'hF0;
	localparam logic [7:0] MODULE_ID_ADDR = 8'hF1;
	localparam logic [7:0] FLAG_SEL_ADDR = 8'hF2;
	localparam logic [7:0] CONTROL_ADDR = 8'hF3;
	localparam int CTRL_BOOT_BIT = 0;
	localparam int CTRL_RESET_BIT = 1;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	typedef enum logic [3:0] {
		SBU_IDLE = 4'h1,
		SBU_WRITE = 4'h2,
		SBU_READ = 4'h4,
		SBU_DONE = 4'h8
	} sbu_state_t;
endpackage

// ==== design/sbu_edge_det.sv ====
// Rising edge detector for a synchronous strobe input.
`timescale 1ns/1ps
module sbu_edge_det (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Sampled level and its rising edge.
	input wire logic level,
	output logic rise
);
	logic prev;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	assign rise = level & ~prev;
endmodule

// ==== design/sbu_user_port.sv ====
// Device end of the multiplexed 8-bit user port and carrier control pins.
`timescale 1ns/1ps
module sbu_user_port #(
	parameter int DATA_W = sbu_pkg::DATA_W,
	parameter int ID_W = sbu_pkg::ID_W,
	parameter int NUM_REGS = sbu_pkg::NUM_REGS
) (
	// Clock and carrier reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Shared data lines, split into input, output and enable.
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	// Strobes and acknowledge.
	input wire logic address_strobe,
	input wire logic data_strobe_n,
	input wire logic read_not_write_select,
	output logic ready_n,
	// Carrier control pins.
	input wire logic flag_function_selector,
	output logic flag_function_active,
	output logic carrier_boot_override_n,
	output logic carrier_reset_out_n,
	input wire logic [ID_W-1:0] carrier_identity_bit,
	input wire logic [ID_W-1:0] module_identity_bit,
	// User logic view of the register file.
	output logic [NUM_REGS*DATA_W-1:0] user_regs
);
	sbu_pkg::sbu_state_t state;
	logic [DATA_W-1:0] address;
	logic [DATA_W-1:0] control;
	logic [DATA_W-1:0] regs [NUM_REGS];
	logic [DATA_W-1:0] read_value;
	logic as_rise;
	logic in_range;
	logic hit_carrier_id;
	logic hit_module_id;
	logic hit_flag_sel;
	logic hit_control;
	sbu_pkg::sbu_state_t next_state;

	sbu_edge_det u_as_edge (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.level(address_strobe),
		.rise(as_rise)
	);

	// Address latch; an address phase never overlaps a data strobe.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			address <= sbu_pkg::ADDR_RESET;
		end else if (as_rise) begin
			address <= data_in;
		end
	end

	assign in_range = address < DATA_W'(NUM_REGS);

	// Fixed locations above the user register range. Every other address
	// reads as zero and swallows writes, so a stray access from a controller
	// with a wrong map cannot disturb the carrier control bits.
	assign hit_carrier_id = address == sbu_pkg::CARRIER_ID_ADDR;
	assign hit_module_id = address == sbu_pkg::MODULE_ID_ADDR;
	assign hit_flag_sel = address == sbu_pkg::FLAG_SEL_ADDR;
	assign hit_control = address == sbu_pkg::CONTROL_ADDR;

	always_comb begin
		read_value = sbu_pkg::REG_RESET;
		if (in_range) begin
			read_value = regs[address[$clog2(NUM_REGS)-1:0]];
		end else if (hit_carrier_id) begin
			read_value = DATA_W'(carrier_identity_bit);
		end else if (hit_module_id) begin
			read_value = DATA_W'(module_identity_bit);
		end else if (hit_flag_sel) begin
			read_value = DATA_W'(flag_function_active);
		end else if (hit_control) begin
			read_value = control;
		end
	end

	// Access timing is counted from the edge that first sees the data strobe
	// low in idle. A write lands in the register file on the following edge,
	// and ready falls on that same edge. A read loads the output register and
	// raises the drive enable on the following edge, and ready falls one edge
	// later, so the byte has stood on the lines for a full cycle before the
	// controller is told to take it. Ready and the drive enable are released
	// together on the edge that first sees the strobe high again, which leaves
	// the lines free before any following address phase. The direction line
	// is only looked at on the first edge; a change in mid-access is ignored.
	// Ready is held until the strobe returns so a slow controller never misses it.
	always_comb begin
		next_state = state;
		case (state)
			sbu_pkg::SBU_IDLE: begin
				if (!data_strobe_n) begin
					if (read_not_write_select) begin
						next_state = sbu_pkg::SBU_READ;
					end else begin
						next_state = sbu_pkg::SBU_WRITE;
					end
				end
			end
			sbu_pkg::SBU_WRITE: begin
				next_state = sbu_pkg::SBU_DONE;
			end
			sbu_pkg::SBU_READ: begin
				next_state = sbu_pkg::SBU_DONE;
			end
			sbu_pkg::SBU_DONE: begin
				if (data_strobe_n) begin
					next_state = sbu_pkg::SBU_IDLE;
				end
			end
			default: begin
				next_state = sbu_pkg::SBU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= sbu_pkg::SBU_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Write data is latched in the write state.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= sbu_pkg::REG_RESET;
			end
			control <= sbu_pkg::CONTROL_RESET;
		end else if (state == sbu_pkg::SBU_WRITE) begin
			if (in_range) begin
				regs[address[$clog2(NUM_REGS)-1:0]] <= data_in;
			end else if (hit_control) begin
				control <= data_in;
			end
		end
	end

	// Read data is driven in the read state, one cycle before ready falls.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			data_out <= sbu_pkg::REG_RESET;
			data_oe <= 1'b0;
		end else if (state == sbu_pkg::SBU_READ) begin
			data_out <= read_value;
			data_oe <= 1'b1;
		end else if (state == sbu_pkg::SBU_DONE && data_strobe_n) begin
			data_oe <= 1'b0;
		end else if (state == sbu_pkg::SBU_IDLE) begin
			data_oe <= 1'b0;
		end
	end

	// Ready stays high through the read state so that it can never fall
	// before the read byte has been on the lines for a whole cycle.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ready_n <= 1'b1;
		end else if (state == sbu_pkg::SBU_WRITE) begin
			ready_n <= 1'b0;
		end else if (state == sbu_pkg::SBU_READ) begin
			ready_n <= 1'b1;
		end else if (state == sbu_pkg::SBU_DONE) begin
			ready_n <= data_strobe_n;
		end else begin
			ready_n <= 1'b1;
		end
	end

	// Carrier control outputs. Both low-active outputs rest high so an
	// unconfigured design never resets or overrides the carrier.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flag_function_active <= 1'b0;
			carrier_boot_override_n <= 1'b1;
			carrier_reset_out_n <= 1'b1;
		end else begin
			flag_function_active <= flag_function_selector;
			carrier_boot_override_n <= ~control[sbu_pkg::CTRL_BOOT_BIT];
			carrier_reset_out_n <= ~control[sbu_pkg::CTRL_RESET_BIT];
		end
	end

	// The user logic sees each register one cycle after the write lands.
	// The copy costs a cycle but keeps every output straight from a flop.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			user_regs <= '0;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				user_regs[i*DATA_W +: DATA_W] <= regs[i];
			end
		end
	end
endmodule

// ==== tb/sbu_chk.sv ====
// Port handshake checker.
`timescale 1ns/1ps
module sbu_chk(input wire logic clk_sys, reset_n, data_strobe_n, read_not_write_select, ready_n, data_oe,
	flag_function_selector, flag_function_active, input wire logic [7:0] data_out);
	wire ds = data_strobe_n, rw = read_not_write_select, rd = ready_n, oe = data_oe;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_wr; $fell(ds) && !rw |-> ##3 !rd; endproperty
	a_wr: assert property (p_wr) else $error("write ack");
	property p_rd; $fell(ds) && rw |-> ##3 oe ##1 !rd; endproperty
	a_rd: assert property (p_rd) else $error("read ack");
	property p_rel; $past(ds) |-> rd && !oe; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_hold; !rd && !ds |=> !rd; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_ord; !rd && rw |-> oe; endproperty
	a_ord: assert property (p_ord) else $error("order");
	property p_dir; !rw |-> !oe; endproperty
	a_dir: assert property (p_dir) else $error("drive");
	property p_stab; oe && $past(oe) |-> $stable(data_out); endproperty
	a_stab: assert property (p_stab) else $error("moved");
	property p_flag; $past(reset_n) |-> flag_function_active == $past(flag_function_selector); endproperty
	a_flag: assert property (p_flag) else $error("flag");
endmodule
bind sbu_user_port sbu_chk u_chk(.*);

// ==== tb/sbu_ctl.sv ====
// Controller model for byte accesses.
`timescale 1ns/1ps
module sbu_ctl(input wire logic clk_sys, data_oe, ready_n, input wire logic [7:0] data_out, output logic [7:0] data_in,
	output logic address_strobe = 1'h0, data_strobe_n = 1'h1, read_not_write_select = 1'h0);
	logic [7:0] bus = 8'h00;
	assign data_in = data_oe ? data_out : bus;
	task automatic acc(input logic rd, input logic [7:0] a, w, output logic [7:0] q);
		bus <= a;
		@(posedge clk_sys) address_strobe <= 1'h1;
		@(posedge clk_sys) address_strobe <= 1'h0;
		read_not_write_select <= rd;
		data_strobe_n <= 1'h0;
		bus <= rd ? ~a : w;
		for (int n = 0; n < 9 && ready_n; n++) @(posedge clk_sys);
		q = data_in;
		data_strobe_n <= 1'h1;
		// Released lines show the inverse of the last byte.
		bus <= ~q;
		@(posedge clk_sys);
	endtask
endmodule

// ==== tb/sbu_user_port_tb_top.sv ====
// User port bench with a byte register model.
`timescale 1ns/1ps
module sbu_user_port_tb_top;
	logic clk_sys = 1'h0, reset_n = 1'h0, flag_function_selector = 1'h1;
	logic [3:0] carrier_identity_bit = 4'h9, module_identity_bit = 4'h6;
	logic [7:0] data_in, data_out, r;
	logic data_oe, address_strobe, data_strobe_n, read_not_write_select, ready_n;
	logic flag_function_active, carrier_boot_override_n, carrier_reset_out_n;
	logic [127:0] user_regs, exp_regs;
	int n_mismatch = 0, n_compared = 0, w, m[256] = '{240: 9, 241: 6, 242: 1, default: 0};
	sbu_user_port u_dut(.*);
	sbu_ctl u_ctl(.*);
	initial forever #25 clk_sys = ~clk_sys;
	initial #1ms begin
		n_mismatch++;
		stop_test();
	end
	task automatic chk(input logic [127:0] g, x);
		n_compared++;
		n_mismatch += g !== x;
		if (g !== x) $display("CHECK FAILED %0t %h %h", $time, g, x);
	endtask
	task automatic stop_test();
		$display("%0d/%0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		void'($urandom(72));
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'h1;
		for (int a = 0; a < 512; a++) begin
			w = $urandom;
			if (a % 256 > 16 && a % 256 < 239) continue;
			flag_function_selector <= w[8];
			m[242] = w[8];
			u_ctl.acc(a > 255, 8'(a), w[7:0], r);
			if (a > 255) chk(r, m[a % 256]);
			else if (a < 16 || a == 243) m[a] = w[7:0];
		end
		for (int i = 0; i < 16; i++) exp_regs[i*8 +: 8] = 8'(m[i]);
		chk(user_regs, exp_regs);
		chk({flag_function_active, carrier_reset_out_n, carrier_boot_override_n}, {1'(m[242]), 2'(~m[243])});
		$display("done");
		reset_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		chk(user_regs, 128'h0);
		chk({carrier_reset_out_n, carrier_boot_override_n, ready_n, data_oe}, 4'hE);
		$display("reset done");
		stop_test();
	end
endmodule
